/* File: shared/bsm_defines.vh */
/*
  Constants of the bank switch address mapper: register indices, field
  positions, reset values and window decode codes.
  Assumes it is included by bare name from the design files.
*/
`ifndef BSM_DEFINES_VH
`define BSM_DEFINES_VH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define BSM_IDX_AREA0 10'h350
`define BSM_IDX_AREA1 10'h351
`define BSM_IDX_AREA2 10'h352
`define BSM_IDX_AREA3 10'h353
`define BSM_IDX_MODE 10'h354

// ****************************************************************
// Field positions and widths.
// ****************************************************************
`define BSM_ENABLE_BIT 7
`define BSM_FIELD3_W 5
`define BSM_FIELD_W 3
`define BSM_MODE_MANY_BIT 0

// ****************************************************************
// Reset values.
// ****************************************************************
`define BSM_BANK_RESET 8'h00
`define BSM_MODE_RESET 1'b0

// ****************************************************************
// Hard-wired logical window codes on the upper address bits.
// ****************************************************************
`define BSM_WIN0_CODE 4'h1
`define BSM_WIN1_CODE 3'h2
`define BSM_WIN2_CODE 3'h6
`define BSM_WIN3_CODE 2'h2

// ****************************************************************
// Bus encodings.
// ****************************************************************
`define BSM_HSIZE_WORD 3'h2
`define BSM_HRESP_OKAY 1'b0

`endif

/* File: hdl/bsm_bank_reg.v */
/*
  One bank select register: an enable bit and a bank field.
  Assumes a write strobe and write data from the bus slave on the same clock.
*/
`timescale 1ns/1ps
`include "bsm_defines.vh"

module bsm_bank_reg #(
  parameter FW = 3
) (
  input wire clk,
  input wire srst,
  input wire wr_en,
  input wire [7:0] wr_data,
  output reg enable_q,
  output reg [FW-1:0] field_q
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  always @(posedge clk)
  begin
    if (srst)
    begin
      enable_q <= 1'b0;
      field_q <= {FW{1'b0}};
    end
    else if (wr_en)
    begin
      enable_q <= wr_data[`BSM_ENABLE_BIT];
      field_q <= wr_data[FW-1:0];
    end
  end

endmodule

/* File: hdl/bsm_mapper_top.v */
/*
  Bank switch address mapper with its AHB-Lite register slave.
  Assumes the logical address and the four chip selects come from the CPU
  and the chip-select/wait controller on the same clock as REF_CLK.
*/
`timescale 1ns/1ps
`include "bsm_defines.vh"

module bsm_mapper_top (
  input wire REF_CLK,
  input wire SRST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg HREADYOUT,
  output reg HRESP,
  output reg [31:0] HRDATA,
  input wire [23:0] LOG_ADDR,
  input wire CHIP_SELECT_ZERO_IN_N,
  input wire CHIP_SELECT_ONE_IN_N,
  input wire CHIP_SELECT_TWO_IN_N,
  input wire CHIP_SELECT_THREE_IN_N,
  output reg [23:0] PHYS_ADDR,
  output reg EXTRA_ADDRESS_LOW,
  output reg EXTRA_ADDRESS_HIGH,
  output reg CHIP_SELECT_ZERO_N,
  output reg CHIP_SELECT_ONE_N,
  output reg CHIP_SELECT_TWO_N,
  output reg CHIP_SELECT_THREE_N,
  output reg EXTENDED_SELECT_A_N,
  output reg EXTENDED_SELECT_B_N,
  output reg EXTENDED_SELECT_C_N,
  output reg EXTENDED_SELECT_D_N,
  output reg EXTENDED_SELECT_E_N
);

  // ****************************************************************
  // Bus address phase decode.
  // ****************************************************************
  wire addr_phase;
  wire [9:0] addr_idx;
  wire addr_hi_zero;
  reg wr_pend_q;
  reg [9:0] wr_idx_q;
  reg many_mem_q;
  reg [31:0] rd_word;
  wire wr_area0;
  wire wr_area1;
  wire wr_area2;
  wire wr_area3;
  wire wr_mode;
  wire [7:0] wr_byte;

  assign addr_phase = HSEL & HREADY & HTRANS[1];
  assign addr_idx = HADDR[11:2];
  assign addr_hi_zero = (HADDR[31:12] == 20'h00000) & (HADDR[1:0] == 2'h0);
  assign wr_byte = HWDATA[7:0];

  // Writes land in the data phase, when HWDATA is valid.
  assign wr_area0 = wr_pend_q & (wr_idx_q == `BSM_IDX_AREA0);
  assign wr_area1 = wr_pend_q & (wr_idx_q == `BSM_IDX_AREA1);
  assign wr_area2 = wr_pend_q & (wr_idx_q == `BSM_IDX_AREA2);
  assign wr_area3 = wr_pend_q & (wr_idx_q == `BSM_IDX_AREA3);
  assign wr_mode = wr_pend_q & (wr_idx_q == `BSM_IDX_MODE);

  always @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 10'h000;
    end
    else
    begin
      wr_pend_q <= addr_phase & HWRITE & addr_hi_zero & (HSIZE == `BSM_HSIZE_WORD);
      wr_idx_q <= addr_idx;
    end
  end

  // ****************************************************************
  // Bank select registers and mode register.
  // ****************************************************************
  wire en0_q;
  wire en1_q;
  wire en2_q;
  wire en3_q;
  wire [`BSM_FIELD_W-1:0] f0_q;
  wire [`BSM_FIELD_W-1:0] f1_q;
  wire [`BSM_FIELD_W-1:0] f2_q;
  wire [`BSM_FIELD3_W-1:0] f3_q;

  bsm_bank_reg #(.FW(`BSM_FIELD_W)) u_area0 (
    .clk(REF_CLK),
    .srst(SRST),
    .wr_en(wr_area0),
    .wr_data(wr_byte),
    .enable_q(en0_q),
    .field_q(f0_q)
  );

  bsm_bank_reg #(.FW(`BSM_FIELD_W)) u_area1 (
    .clk(REF_CLK),
    .srst(SRST),
    .wr_en(wr_area1),
    .wr_data(wr_byte),
    .enable_q(en1_q),
    .field_q(f1_q)
  );

  bsm_bank_reg #(.FW(`BSM_FIELD_W)) u_area2 (
    .clk(REF_CLK),
    .srst(SRST),
    .wr_en(wr_area2),
    .wr_data(wr_byte),
    .enable_q(en2_q),
    .field_q(f2_q)
  );

  bsm_bank_reg #(.FW(`BSM_FIELD3_W)) u_area3 (
    .clk(REF_CLK),
    .srst(SRST),
    .wr_en(wr_area3),
    .wr_data(wr_byte),
    .enable_q(en3_q),
    .field_q(f3_q)
  );

  // Mode resets to standard so boot fetches use chip select two.
  always @(posedge REF_CLK)
  begin
    if (SRST)
      many_mem_q <= `BSM_MODE_RESET;
    else if (wr_mode)
      many_mem_q <= wr_byte[`BSM_MODE_MANY_BIT];
  end

  // ****************************************************************
  // Read data; a write in its data phase is forwarded to a read.
  // ****************************************************************
  always @*
  begin
    rd_word = 32'h00000000;
    case (addr_idx)
      `BSM_IDX_AREA0:
        rd_word = {24'h000000, en0_q, 4'h0, f0_q};
      `BSM_IDX_AREA1:
        rd_word = {24'h000000, en1_q, 4'h0, f1_q};
      `BSM_IDX_AREA2:
        rd_word = {24'h000000, en2_q, 4'h0, f2_q};
      `BSM_IDX_AREA3:
        rd_word = {24'h000000, en3_q, 2'h0, f3_q};
      `BSM_IDX_MODE:
        rd_word = {31'h00000000, many_mem_q};
      default:
        rd_word = 32'h00000000;
    endcase
    if (wr_pend_q & (wr_idx_q == addr_idx))
    begin
      case (addr_idx)
        `BSM_IDX_AREA0, `BSM_IDX_AREA1, `BSM_IDX_AREA2:
          rd_word = {24'h000000, wr_byte[7], 4'h0, wr_byte[2:0]};
        `BSM_IDX_AREA3:
          rd_word = {24'h000000, wr_byte[7], 2'h0, wr_byte[4:0]};
        `BSM_IDX_MODE:
          rd_word = {31'h00000000, wr_byte[0]};
        default:
          rd_word = 32'h00000000;
      endcase
    end
    if (!addr_hi_zero)
      rd_word = 32'h00000000;
  end

  always @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      HREADYOUT <= 1'b1;
      HRESP <= `BSM_HRESP_OKAY;
      HRDATA <= 32'h00000000;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP <= `BSM_HRESP_OKAY;
      if (addr_phase & ~HWRITE)
        HRDATA <= rd_word;
    end
  end

  // ****************************************************************
  // Window decode on fixed logical ranges.
  // ****************************************************************
  wire in_w0;
  wire in_w1;
  wire in_w2;
  wire in_w3;
  wire hit0;
  wire hit1;
  wire hit2;
  wire hit3;

  assign in_w0 = (LOG_ADDR[23:20] == `BSM_WIN0_CODE);
  assign in_w1 = (LOG_ADDR[23:21] == `BSM_WIN1_CODE);
  assign in_w2 = (LOG_ADDR[23:21] == `BSM_WIN2_CODE);
  assign in_w3 = (LOG_ADDR[23:22] == `BSM_WIN3_CODE);
  assign hit0 = in_w0 & en0_q;
  assign hit1 = in_w1 & en1_q;
  assign hit2 = in_w2 & en2_q;
  assign hit3 = in_w3 & en3_q;

  // ****************************************************************
  // Physical address and extended address lines.
  // ****************************************************************
  reg [23:0] phys_d;
  reg ea_lo_d;
  reg ea_hi_d;

  always @*
  begin
    phys_d = LOG_ADDR;
    ea_lo_d = 1'b0;
    ea_hi_d = 1'b0;
    if (hit0)
      phys_d[22:20] = f0_q;
    if (hit1)
      phys_d[23:21] = f1_q;
    if (hit2)
      phys_d[23:21] = f2_q;
    if (hit3)
    begin
      phys_d[23:22] = f3_q[1:0];
      ea_lo_d = ~many_mem_q & f3_q[2];
      ea_hi_d = ~many_mem_q & f3_q[3];
    end
  end

  // ****************************************************************
  // Chip select routing.
  // ****************************************************************
  reg [3:0] cs_n_d;
  reg [4:0] ext_n_d;

  always @*
  begin
    cs_n_d = {CHIP_SELECT_THREE_IN_N, CHIP_SELECT_TWO_IN_N,
              CHIP_SELECT_ONE_IN_N, CHIP_SELECT_ZERO_IN_N};
    ext_n_d = 5'h1F;
    if (many_mem_q)
    begin
      cs_n_d[2] = 1'b1;
      if (!CHIP_SELECT_TWO_IN_N)
      begin
        if (hit3)
        begin
          case (f3_q)
            5'h00, 5'h01, 5'h02, 5'h03:
              ext_n_d[1] = 1'b0;
            5'h04, 5'h05, 5'h06, 5'h07:
              ext_n_d[2] = 1'b0;
            5'h08, 5'h09, 5'h0A, 5'h0B:
              ext_n_d[3] = 1'b0;
            5'h0C, 5'h0D, 5'h0E, 5'h0F:
              ext_n_d[4] = 1'b0;
            default:
              ext_n_d = 5'h1F;
          endcase
        end
        else
          ext_n_d[0] = 1'b0;
      end
    end
  end

  // ****************************************************************
  // Registered memory-side outputs.
  // ****************************************************************
  always @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      PHYS_ADDR <= 24'h000000;
      EXTRA_ADDRESS_LOW <= 1'b0;
      EXTRA_ADDRESS_HIGH <= 1'b0;
      CHIP_SELECT_ZERO_N <= 1'b1;
      CHIP_SELECT_ONE_N <= 1'b1;
      CHIP_SELECT_TWO_N <= 1'b1;
      CHIP_SELECT_THREE_N <= 1'b1;
      EXTENDED_SELECT_A_N <= 1'b1;
      EXTENDED_SELECT_B_N <= 1'b1;
      EXTENDED_SELECT_C_N <= 1'b1;
      EXTENDED_SELECT_D_N <= 1'b1;
      EXTENDED_SELECT_E_N <= 1'b1;
    end
    else
    begin
      PHYS_ADDR <= phys_d;
      EXTRA_ADDRESS_LOW <= ea_lo_d;
      EXTRA_ADDRESS_HIGH <= ea_hi_d;
      CHIP_SELECT_ZERO_N <= cs_n_d[0];
      CHIP_SELECT_ONE_N <= cs_n_d[1];
      CHIP_SELECT_TWO_N <= cs_n_d[2];
      CHIP_SELECT_THREE_N <= cs_n_d[3];
      EXTENDED_SELECT_A_N <= ext_n_d[0];
      EXTENDED_SELECT_B_N <= ext_n_d[1];
      EXTENDED_SELECT_C_N <= ext_n_d[2];
      EXTENDED_SELECT_D_N <= ext_n_d[3];
      EXTENDED_SELECT_E_N <= ext_n_d[4];
    end
  end

endmodule

/* File: test/bsm_mapper_monitor.sv */
/*
  Checks on the memory side ports of the mapper top.
  Assumes a bind from the bench top file.
*/
`timescale 1ns/1ps
module bsm_mapper_monitor (
  input wire REF_CLK,
  input wire SRST,
  input wire [23:0] LOG_ADDR,
  input wire CHIP_SELECT_TWO_IN_N,
  input wire CHIP_SELECT_THREE_IN_N,
  input wire [23:0] PHYS_ADDR,
  input wire EXTRA_ADDRESS_LOW,
  input wire EXTRA_ADDRESS_HIGH,
  input wire CHIP_SELECT_TWO_N,
  input wire CHIP_SELECT_THREE_N,
  input wire EXTENDED_SELECT_A_N,
  input wire EXTENDED_SELECT_B_N,
  input wire EXTENDED_SELECT_C_N,
  input wire EXTENDED_SELECT_D_N,
  input wire EXTENDED_SELECT_E_N
);
  wire [4:0] ext_n = {EXTENDED_SELECT_A_N, EXTENDED_SELECT_B_N, EXTENDED_SELECT_C_N,
    EXTENDED_SELECT_D_N, EXTENDED_SELECT_E_N};
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);
  low_bits_a: assert property (1'b1
    |=> PHYS_ADDR[19:0] == $past(LOG_ADDR[19:0])) else $error("low bits changed");
  zero_pass_a: assert property (LOG_ADDR[23:20] == 4'h0
    |=> PHYS_ADDR == $past(LOG_ADDR)) else $error("area zero translated");
  gap_pass_a: assert property (LOG_ADDR[23:21] == 3'h1
    |=> PHYS_ADDR == $past(LOG_ADDR)) else $error("gap area translated");
  top_pass_a: assert property (LOG_ADDR[23:21] == 3'h7
    |=> PHYS_ADDR == $past(LOG_ADDR)) else $error("top area translated");
  extra_line_a: assert property (LOG_ADDR[23:22] != 2'h2
    |=> !EXTRA_ADDRESS_LOW && !EXTRA_ADDRESS_HIGH) else $error("extra line set");
  ext_one_a: assert property ($onehot0(~ext_n))
    else $error("two extended selects low");
  ext_cause_a: assert property (CHIP_SELECT_TWO_IN_N
    |=> ext_n == 5'h1F && CHIP_SELECT_TWO_N) else $error("select without cause");
  sel_three_a: assert property (1'b1
    |=> CHIP_SELECT_THREE_N == $past(CHIP_SELECT_THREE_IN_N)) else $error("select three lost");
  cover property (!EXTENDED_SELECT_B_N);
  cover property (EXTRA_ADDRESS_LOW && !CHIP_SELECT_THREE_N);
  cover property (!EXTENDED_SELECT_A_N);
endmodule

/* File: test/bsm_mem_model.sv */
/*
  Model of the external memory chips.
  Assumes the mapper outputs on the same clock.
*/
`timescale 1ns/1ps
module bsm_mem_model (
  input wire clk,
  input wire [25:0] paddr,
  input wire [8:0] sel_n,
  output reg [25:0] loc,
  output reg hit
);
  always @(posedge clk)
  begin
    loc <= paddr;
    hit <= ~&sel_n;
  end
endmodule

/* File: test/bank_switch_address_mapper_tb.sv */
/*
  Self-checking bench of the mapper with a memory model.
  Assumes the design, its defines, the model and the monitor are compiled.
*/
`timescale 1ns/1ps
`include "bsm_defines.vh"
module bank_switch_address_mapper_tb;
  reg clk, srst, hsel, hwrite, md;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [31:0] haddr, hwdata, q, rv;
  reg [23:0] la;
  reg [3:0] csn;
  reg [11:0] a;
  reg [7:0] r [0:3];
  wire hrdy, hresp, hit;
  wire [31:0] hrdata;
  wire [23:0] pa;
  wire [1:0] ea;
  wire [3:0] cso;
  wire [4:0] exo;
  wire [25:0] loc;
  integer seed, num_errors, compares, cyc, i;
  bsm_mapper_top dut_u (.REF_CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy),
    .HREADYOUT(hrdy), .HRESP(hresp), .HRDATA(hrdata), .LOG_ADDR(la),
    .CHIP_SELECT_ZERO_IN_N(csn[0]), .CHIP_SELECT_ONE_IN_N(csn[1]),
    .CHIP_SELECT_TWO_IN_N(csn[2]), .CHIP_SELECT_THREE_IN_N(csn[3]), .PHYS_ADDR(pa),
    .EXTRA_ADDRESS_LOW(ea[0]), .EXTRA_ADDRESS_HIGH(ea[1]), .CHIP_SELECT_ZERO_N(cso[0]),
    .CHIP_SELECT_ONE_N(cso[1]), .CHIP_SELECT_TWO_N(cso[2]), .CHIP_SELECT_THREE_N(cso[3]),
    .EXTENDED_SELECT_A_N(exo[4]), .EXTENDED_SELECT_B_N(exo[3]), .EXTENDED_SELECT_C_N(exo[2]),
    .EXTENDED_SELECT_D_N(exo[1]), .EXTENDED_SELECT_E_N(exo[0]));
  bsm_mem_model mem_u (.clk(clk), .paddr({ea, pa}), .sel_n({cso, exo}), .loc(loc), .hit(hit));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function [34:0] eout(input [23:0] x, input [3:0] c);
    reg [23:0] p;
    reg [1:0] e;
    reg [3:0] o;
    reg [4:0] s, f;
    reg h;
  begin
    {p, e, o, s, f} = {x, 2'h0, c, 5'h1F, r[3][4:0]};
    h = r[3][7] && x[23:22] == 2'h2;
    if (r[0][7] && x[23:20] == 4'h1)
      p[22:20] = r[0][2:0];
    if (r[1][7] && x[23:21] == 3'h2)
      p[23:21] = r[1][2:0];
    if (r[2][7] && x[23:21] == 3'h6)
      p[23:21] = r[2][2:0];
    if (h)
      {e, p[23:22]} = md ? {2'h0, f[1:0]} : f[3:0];
    if (md)
    begin
      o[2] = 1'b1;
      if (!c[2] && !h)
        s[4] = 1'b0;
      if (!c[2] && h && !f[4])
        s[3 - f[3:2]] = 1'b0;
    end
    eout = {p, e, o, s};
  end
  endfunction
  task chk(input [34:0] s, input [34:0] e, input [23:0] n);
  begin
    compares = compares + 1;
    if (s !== e)
    begin
      num_errors = num_errors + 1;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  end
  endtask
  task xfer(input w, input [11:0] ad, input [31:0] d, input [2:0] z);
  begin
    {hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'h2, w, z, 20'h0, ad};
    if (w)
      la <= 24'hE00000;
    @(posedge clk);
    while (hrdy !== 1'b1)
      @(posedge clk);
    {htrans, hwdata} <= {2'h0, d};
    @(posedge clk);
    while (hrdy !== 1'b1)
      @(posedge clk);
    q = hrdata;
    if (w && z == `BSM_HSIZE_WORD && ad >= 12'hD40 && ad < 12'hD54)
    begin
      if (ad[4])
        md = d[0];
      else
        r[ad[3:2]] = d[7:0] & (ad[3:2] == 2'h3 ? 8'h9F : 8'h87);
    end
  end
  endtask
  task rd(input [11:0] ad);
  begin
    xfer(1'b0, ad, 32'h0, `BSM_HSIZE_WORD);
    rv = (ad < 12'hD40 || ad > 12'hD50) ? 32'h0 : ad[4] ? {31'h0, md} : {24'h0, r[ad[3:2]]};
    chk({3'h0, q}, {3'h0, rv}, "reg");
    chk({34'h0, hresp}, {34'h0, `BSM_HRESP_OKAY}, "rsp");
  end
  endtask
  task mchk(input [23:0] x, input [3:0] c);
  begin
    {la, csn} <= {x, c};
    @(posedge clk);
    @(posedge clk);
    chk({pa, ea, cso, exo}, eout(x, c), "map");
  end
  endtask
  task summarize;
  begin
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc > 5000)
    begin
      num_errors = num_errors + 1;
      summarize;
    end
  end
  initial
  begin
    {srst, hsel, htrans, hwrite, hsize, haddr, hwdata} = {1'b1, 71'h0};
    {la, csn, md, seed, num_errors, compares, cyc} = {24'h0, 4'hF, 1'b0, 32'd25, 96'h0};
    for (i = 0; i < 4; i = i + 1)
      r[i] = 8'h00;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (a = 12'hD40; a < 12'hD58; a = a + 12'h4)
      rd(a);
    mchk(24'hC12345, 4'hB);
    mchk(24'h9ABCDE, 4'h7);
    xfer(1'b1, 12'hD4C, 32'hFFFF_FF85, `BSM_HSIZE_WORD);
    mchk(24'h800000, 4'h7);
    @(posedge clk);
    chk({8'h0, hit, loc}, {8'h0, 1'b1, 26'h1400000}, "loc");
    xfer(1'b1, 12'hD4C, 32'h0, 3'h0);
    rd(12'hD4C);
    xfer(1'b1, 12'hD50, 32'h1, `BSM_HSIZE_WORD);
    for (i = 0; i < 32; i = i + 1)
    begin
      xfer(1'b1, 12'hD4C, 32'h80 + i, `BSM_HSIZE_WORD);
      mchk(24'h9ABCDE, 4'hB);
    end
    mchk(24'hC54321, 4'hB);
    for (i = 0; i < 400; i = i + 1)
    begin
      rv = $random(seed);
      if (i % 16 == 0)
      begin
        a = 12'hD40 + {7'h0, rv[2:0] % 3'h5, 2'h0};
        xfer(1'b1, a, rv, `BSM_HSIZE_WORD);
        rd(a);
        rv = $random(seed);
      end
      mchk(rv[23:0], rv[27:24]);
    end
    summarize;
  end
endmodule
bind bsm_mapper_top bsm_mapper_monitor mon_u (.REF_CLK, .SRST, .LOG_ADDR,
  .CHIP_SELECT_TWO_IN_N, .CHIP_SELECT_THREE_IN_N, .PHYS_ADDR, .EXTRA_ADDRESS_LOW,
  .EXTRA_ADDRESS_HIGH, .CHIP_SELECT_TWO_N, .CHIP_SELECT_THREE_N, .EXTENDED_SELECT_A_N,
  .EXTENDED_SELECT_B_N, .EXTENDED_SELECT_C_N, .EXTENDED_SELECT_D_N, .EXTENDED_SELECT_E_N);
